// ---- verilog/port_ocp_defines.svh ----
// offsets, field positions, reset values and timing counts for the port fault timers
// assumes a 25 MHz system clock and a same-clock register port
`ifndef PORT_OCP_DEFINES_SVH
`define PORT_OCP_DEFINES_SVH
`define FAULT_FLAGS_ADDR   8'h06
`define FAULT_CLEAR_ADDR   8'h07
`define TIMER_CFG_ADDR     8'h16
`define TIMER_CFG_RESET    8'h00
`define CFG_DIS_LSB        0
`define CFG_OVL_LSB        2
`define CFG_START_LSB      4
`define FLAGS_OVL_LSB      0
`define FLAGS_START_LSB    4
`define CLK_MHZ            25
`define TICK_US            1000
`define TICK_CYCLES        (`TICK_US * `CLK_MHZ)
`define DOWN_DIVIDE        16
`define SHORT_HOLD_US      100
`define SHORT_HOLD_CYCLES  (`SHORT_HOLD_US * `CLK_MHZ)
`define OVL_MS_0           60
`define OVL_MS_1           30
`define OVL_MS_2           120
`define OVL_MS_3           240
`define START_MS_0         60
`define START_MS_1         30
`define START_MS_2         120
`define START_MS_3         240
`define DIS_MS_0           300
`define DIS_MS_1           75
`define DIS_MS_2           150
`define DIS_MS_3           600
`define FOLD_FULL_TENTH_MV 2125
`define FOLD_MIN_TENTH_MV  300
`define FOLD_KNEE_DECIVOLT 180
`endif

// ---- verilog/port_ocp_pkg.sv ----
// types shared by the port fault timer block
// assumes nothing outside itself
package port_ocp_pkg;
  typedef enum logic [1:0] {
    PS_OFF   = 2'b00,
    PS_START = 2'b01,
    PS_ON    = 2'b11
  } port_state_t;
  typedef logic [9:0] tick_count_t;
endpackage

// ---- verilog/port_overcurrent_fault_timers.sv ----
// four-port overload, start-up, disconnect and short-circuit timers with fault register
// assumes comparator levels from pins, host commands and register port on clk_sys
`include "port_ocp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module port_overcurrent_fault_timers
  import port_ocp_pkg::*;
#(
  parameter int NUM_PORTS   = 4,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  input  wire logic [NUM_PORTS-1:0]       overload_sense_above,
  input  wire logic [NUM_PORTS-1:0]       short_sense_above,
  input  wire logic [NUM_PORTS-1:0]       load_current_low,
  input  wire logic [NUM_PORTS-1:0][7:0]  port_voltage,
  input  wire logic [NUM_PORTS-1:0]       auto_mode,
  input  wire logic [NUM_PORTS-1:0]       disconnect_enable,
  input  wire logic [NUM_PORTS-1:0]       power_on_cmd,
  input  wire logic [NUM_PORTS-1:0]       power_off_cmd,
  input  wire logic [NUM_PORTS-1:0]       detect_begin,
  input  wire logic [NUM_PORTS-1:0]       detect_good,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [7:0]                 reg_wdata,
  output logic      [7:0]                 reg_rdata,
  output logic      [NUM_PORTS-1:0]       port_powered,
  output logic      [NUM_PORTS-1:0]       gate_drive_on,
  output logic      [NUM_PORTS-1:0]       gate_pulldown,
  output logic      [NUM_PORTS-1:0]       disconnect_active,
  output logic      [NUM_PORTS-1:0]       overload_timer_zero,
  output logic      [NUM_PORTS-1:0][11:0] current_limit_sense_level
);

  localparam int          TICK_W     = $clog2(TICK_CYCLES);
  localparam logic [11:0] SHORT_HOLD = 12'(`SHORT_HOLD_CYCLES);

  function automatic tick_count_t dur_ms(input logic [1:0] sel, input int m0, input int m1,
                                         input int m2, input int m3);
    unique case (sel)
      2'b00: dur_ms = tick_count_t'(m0);
      2'b01: dur_ms = tick_count_t'(m1);
      2'b10: dur_ms = tick_count_t'(m2);
      2'b11: dur_ms = tick_count_t'(m3);
    endcase
  endfunction

  logic [7:0]        cfg_reg;
  logic [7:0]        flags_reg;
  logic [TICK_W-1:0] presc_reg;
  logic [3:0]        slow_reg;
  logic [NUM_PORTS-1:0] ovl_set;
  logic [NUM_PORTS-1:0] start_set;

  // shared time base: one tick per millisecond, slow tick every sixteenth
  wire tick      = (presc_reg == TICK_W'(TICK_CYCLES - 1));
  wire slow_tick = tick && (slow_reg == 4'(`DOWN_DIVIDE - 1));

  wire tick_count_t ovl_lim   = dur_ms(cfg_reg[`CFG_OVL_LSB +: 2], `OVL_MS_0, `OVL_MS_1,
                                       `OVL_MS_2, `OVL_MS_3);
  wire tick_count_t start_lim = dur_ms(cfg_reg[`CFG_START_LSB +: 2], `START_MS_0, `START_MS_1,
                                       `START_MS_2, `START_MS_3);
  wire tick_count_t dis_lim   = dur_ms(cfg_reg[`CFG_DIS_LSB +: 2], `DIS_MS_0, `DIS_MS_1,
                                       `DIS_MS_2, `DIS_MS_3);

  wire       wr_cfg    = reg_wr && (reg_addr == `TIMER_CFG_ADDR);
  wire       rd_clear  = reg_rd && (reg_addr == `FAULT_CLEAR_ADDR);
  wire [7:0] fault_set = {start_set, ovl_set};
  // set wins over the clear-on-read
  wire [7:0] flags_next = (rd_clear ? 8'h00 : flags_reg) | fault_set;
  wire [7:0] rdata_next = (reg_addr == `FAULT_FLAGS_ADDR || reg_addr == `FAULT_CLEAR_ADDR) ?
                          flags_reg : (reg_addr == `TIMER_CFG_ADDR) ? cfg_reg : 8'h00;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      presc_reg <= '0;
      slow_reg  <= 4'h0;
      cfg_reg   <= `TIMER_CFG_RESET;
      flags_reg <= 8'h00;
      reg_rdata <= 8'h00;
    end else begin
      presc_reg <= tick ? '0 : presc_reg + TICK_W'(1);
      slow_reg  <= tick ? slow_reg + 4'h1 : slow_reg;
      cfg_reg   <= wr_cfg ? reg_wdata : cfg_reg;
      flags_reg <= flags_next;
      reg_rdata <= reg_rd ? rdata_next : reg_rdata;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [2:0]  ovl_sync_reg;
      logic [2:0]  short_sync_reg;
      logic [2:0]  low_sync_reg;
      logic        ovl_reg;
      logic        short_reg;
      logic        low_reg;
      port_state_t state_reg;
      port_state_t state_next;
      tick_count_t fault_cnt_reg;
      tick_count_t fault_cnt_next;
      tick_count_t start_cnt_reg;
      tick_count_t dis_cnt_reg;
      logic        all_limited_reg;
      logic        armed_reg;
      logic        pulldown_reg;
      logic [11:0] hold_cnt_reg;
      logic [11:0] level_reg;
      logic        powered_reg;
      logic        gate_reg;
      logic        disc_act_reg;
      logic        zero_reg;

      wire          powered   = (state_reg != PS_OFF);
      wire          cnt_zero  = (fault_cnt_reg == '0);
      wire tick_count_t lim   = (state_reg == PS_START) ? start_lim : ovl_lim;
      // counting runs on the sense comparator alone, so foldback limiting still counts
      wire          expire    = powered && ovl_reg && (fault_cnt_reg >= lim);
      wire          start_end = (state_reg == PS_START) && tick &&
                                (start_cnt_reg == lim - tick_count_t'(1));
      // count reaching full on the last start-up tick still means limited throughout
      wire          start_flt = (state_reg == PS_START) &&
                                (expire || (start_end && ovl_reg &&
                                 (all_limited_reg || (fault_cnt_next >= lim))));
      wire          ovl_flt   = (state_reg == PS_ON) && expire;
      wire          dis_run   = (state_reg == PS_ON) && disconnect_enable[p] && low_reg;
      wire          dis_flt   = dis_run && tick && (dis_cnt_reg == dis_lim - tick_count_t'(1));
      // power-on requests are ignored until the count is back at zero
      wire          turn_on   = !powered && cnt_zero &&
                                (auto_mode[p] ? (detect_good[p] && armed_reg)
                                              : power_on_cmd[p]);
      wire          short_hit = short_reg && !pulldown_reg && powered;
      wire          release_g = pulldown_reg && (hold_cnt_reg == SHORT_HOLD - 12'h001);
      wire          pd_next   = short_hit || (pulldown_reg && !release_g);
      wire [19:0]   fold_prod = 20'(`FOLD_FULL_TENTH_MV - `FOLD_MIN_TENTH_MV) *
                                20'(port_voltage[p]);
      wire [11:0]   fold_lvl  = (port_voltage[p] >= 8'(`FOLD_KNEE_DECIVOLT)) ?
                                12'(`FOLD_FULL_TENTH_MV) :
                                12'(`FOLD_MIN_TENTH_MV) +
                                12'(fold_prod / 20'(`FOLD_KNEE_DECIVOLT));

      always_comb begin
        fault_cnt_next = fault_cnt_reg;
        if (powered && ovl_reg && tick && (fault_cnt_reg < lim)) begin
          fault_cnt_next = fault_cnt_reg + tick_count_t'(1);
        end else if (!ovl_reg && slow_tick && !cnt_zero) begin
          fault_cnt_next = fault_cnt_reg - tick_count_t'(1);
        end
      end

      always_comb begin
        state_next = state_reg;
        unique case (state_reg)
          PS_OFF: begin
            if (turn_on) state_next = PS_START;
          end
          PS_START: begin
            if (start_flt || power_off_cmd[p]) state_next = PS_OFF;
            else if (start_end) state_next = PS_ON;
          end
          PS_ON: begin
            if (ovl_flt || dis_flt || power_off_cmd[p]) state_next = PS_OFF;
          end
          default: state_next = PS_OFF;
        endcase
      end

      assign ovl_set[p]   = ovl_flt;
      assign start_set[p] = start_flt;
      assign port_powered[p]              = powered_reg;
      assign gate_drive_on[p]             = gate_reg;
      assign gate_pulldown[p]             = pulldown_reg;
      assign disconnect_active[p]         = disc_act_reg;
      assign overload_timer_zero[p]       = zero_reg;
      assign current_limit_sense_level[p] = level_reg;

      // pin levels: change taken once second and third stages agree
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          ovl_sync_reg   <= 3'h0;
          short_sync_reg <= 3'h0;
          low_sync_reg   <= 3'h0;
          ovl_reg        <= 1'b0;
          short_reg      <= 1'b0;
          low_reg        <= 1'b0;
        end else begin
          ovl_sync_reg   <= {ovl_sync_reg[1:0], overload_sense_above[p]};
          short_sync_reg <= {short_sync_reg[1:0], short_sense_above[p]};
          low_sync_reg   <= {low_sync_reg[1:0], load_current_low[p]};
          ovl_reg        <= (ovl_sync_reg[2] == ovl_sync_reg[1]) ? ovl_sync_reg[2] : ovl_reg;
          short_reg      <= (short_sync_reg[2] == short_sync_reg[1]) ? short_sync_reg[2] : short_reg;
          low_reg        <= (low_sync_reg[2] == low_sync_reg[1]) ? low_sync_reg[2] : low_reg;
        end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          state_reg       <= PS_OFF;
          fault_cnt_reg   <= '0;
          start_cnt_reg   <= '0;
          dis_cnt_reg     <= '0;
          all_limited_reg <= 1'b0;
          armed_reg       <= 1'b0;
        end else begin
          state_reg       <= state_next;
          fault_cnt_reg   <= fault_cnt_next;
          start_cnt_reg   <= turn_on ? '0 :
                             ((state_reg == PS_START) && tick) ? start_cnt_reg + tick_count_t'(1) :
                             start_cnt_reg;
          dis_cnt_reg     <= !dis_run ? '0 : tick ? dis_cnt_reg + tick_count_t'(1) : dis_cnt_reg;
          all_limited_reg <= turn_on ? 1'b1 : all_limited_reg && ovl_reg;
          // detection must begin with the count already at zero
          armed_reg       <= (powered || !cnt_zero) ? 1'b0 :
                             detect_begin[p] ? 1'b1 : armed_reg;
        end
      end

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          pulldown_reg <= 1'b0;
          hold_cnt_reg <= 12'h000;
          level_reg    <= 12'h000;
          powered_reg  <= 1'b0;
          gate_reg     <= 1'b0;
          disc_act_reg <= 1'b0;
          zero_reg     <= 1'b1;
        end else begin
          pulldown_reg <= pd_next;
          hold_cnt_reg <= pulldown_reg ? hold_cnt_reg + 12'h001 : 12'h000;
          level_reg    <= fold_lvl;
          powered_reg  <= (state_next != PS_OFF);
          gate_reg     <= (state_next != PS_OFF) && !pd_next;
          disc_act_reg <= (state_next == PS_ON) && disconnect_enable[p];
          zero_reg     <= (fault_cnt_next == '0);
        end
      end
    end
  endgenerate

endmodule // port_overcurrent_fault_timers
`default_nettype wire

// ---- test/port_load_model.sv ----
// load and pass transistor seen from the fault timer pins
// bench sets the requests; short current only flows through a driven gate, overload sense follows its request
`timescale 1ns/1ps
`default_nettype none
module port_load_model (
  input  wire logic [3:0] ovl_req,
  input  wire logic [3:0] short_req,
  input  wire logic [3:0] low_req,
  input  wire logic [3:0] gate_drive_on,
  output logic      [3:0] overload_sense_above,
  output logic      [3:0] short_sense_above,
  output logic      [3:0] load_current_low
);
  // short current collapses once the gate is pulled down
  assign short_sense_above    = short_req & gate_drive_on;
  assign overload_sense_above = ovl_req;
  // an undriven port draws nothing
  assign load_current_low     = low_req | ~gate_drive_on;
endmodule // port_load_model
`default_nettype wire

// ---- test/port_overcurrent_fault_timers_asserts.sv ----
// port-level assertions for the four-port fault timers
// bound to every instance of the top module
`include "port_ocp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module port_overcurrent_fault_timers_asserts #(
  parameter int NUM_PORTS = 4
) (
  input wire logic                 clk_sys,
  input wire logic                 reset_n,
  input wire logic [7:0]           reg_addr,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_wdata,
  input wire logic [7:0]           reg_rdata,
  input wire logic [NUM_PORTS-1:0] port_powered,
  input wire logic [NUM_PORTS-1:0] gate_drive_on,
  input wire logic [NUM_PORTS-1:0] gate_pulldown,
  input wire logic [NUM_PORTS-1:0] disconnect_active,
  input wire logic [NUM_PORTS-1:0] overload_timer_zero
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [7:0]  cfg_reg;
  logic [11:0] pd_cnt_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) cfg_reg <= 8'h00;
    else if (reg_wr && reg_addr == `TIMER_CFG_ADDR) cfg_reg <= reg_wdata;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) pd_cnt_reg <= 12'h000;
    else pd_cnt_reg <= gate_pulldown[2] ? pd_cnt_reg + 12'h001 : 12'h000;
  end
  sequence s_cfg_read;
    reg_rd && !reg_wr && reg_addr == `TIMER_CFG_ADDR;
  endsequence
  sequence s_power_rise;
    $rose(port_powered[0]);
  endsequence
  a_cfg_read_back: assert property (s_cfg_read |=> reg_rdata == cfg_reg)
    else $error("config readback differs");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pulldown_gate_off: assert property ((gate_pulldown & gate_drive_on) == '0)
    else $error("gate driven during pull-down");
  a_pulldown_held: assert property ($rose(gate_pulldown[2]) |=> gate_pulldown[2] [*8])
    else $error("pull-down released early");
  a_pulldown_bound: assert property (pd_cnt_reg <= 12'd2500)
    else $error("pull-down held too long");
  a_gate_needs_power: assert property ((gate_drive_on & ~port_powered) == '0)
    else $error("gate on while unpowered");
  a_repower_at_zero: assert property (s_power_rise |-> $past(overload_timer_zero[0]))
    else $error("powered with timer nonzero");
  a_off_stays_off: assert property (!overload_timer_zero[0] && !port_powered[0]
    |=> !port_powered[0])
    else $error("repowered before timer zero");
  a_disc_held_start: assert property (s_power_rise |-> !disconnect_active[0] [*8])
    else $error("disconnect active in start-up");
  a_disc_needs_power: assert property ((disconnect_active & ~port_powered) == '0)
    else $error("disconnect active while off");
endmodule // port_overcurrent_fault_timers_asserts
bind port_overcurrent_fault_timers port_overcurrent_fault_timers_asserts #(
  .NUM_PORTS(NUM_PORTS)) i_asserts (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .port_powered(port_powered), .gate_drive_on(gate_drive_on),
  .gate_pulldown(gate_pulldown), .disconnect_active(disconnect_active),
  .overload_timer_zero(overload_timer_zero));
`default_nettype wire

// ---- test/port_overcurrent_fault_timers_tb_top.sv ----
// self-checking bench for the four-port fault timers
// drives pins and register port; load model stands at the far side
`include "port_ocp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module port_overcurrent_fault_timers_tb_top;
  localparam int TK = 25;
  logic             clk_sys = 1'b0;
  logic             reset_n = 1'b0;
  logic [3:0]       ovl = '0, shr = '0, lowr = '0, am = '0, den = '0;
  logic [3:0]       pon = '0, poff = '0, db = '0, dg = '0;
  logic [3:0][7:0]  pv = '0;
  logic [7:0]       ra = '0, wd = '0, d, rdata;
  logic             wr = 1'b0, rd = 1'b0;
  logic [3:0]       os, ss, ll, pwr, gon, gpd, dact, tz;
  logic [3:0][11:0] lvl;
  int               n_errors = 0, check_count = 0, cyc = 0, n;
  port_load_model i_load (.ovl_req(ovl), .short_req(shr), .low_req(lowr),
    .gate_drive_on(gon), .overload_sense_above(os), .short_sense_above(ss),
    .load_current_low(ll));
  port_overcurrent_fault_timers #(.NUM_PORTS(4), .TICK_CYCLES(TK)) i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .overload_sense_above(os),
    .short_sense_above(ss), .load_current_low(ll), .port_voltage(pv), .auto_mode(am),
    .disconnect_enable(den), .power_on_cmd(pon), .power_off_cmd(poff),
    .detect_begin(db), .detect_good(dg), .reg_addr(ra), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wd), .reg_rdata(rdata), .port_powered(pwr), .gate_drive_on(gon),
    .gate_pulldown(gpd), .disconnect_active(dact), .overload_timer_zero(tz),
    .current_limit_sense_level(lvl));
  always #20 clk_sys = ~clk_sys;
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 40000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
    step(1); ra = a; wd = v; wr = 1'b1;
    step(1); wr = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    step(1); ra = a; rd = 1'b1;
    step(1); rd = 1'b0;
  endtask
  // 0 power on, 1 power off, 2 detect begin, 3 detect good
  task automatic pulse(input int k, input logic [3:0] m);
    step(1);
    case (k)
      0: pon = m;
      1: poff = m;
      2: db = m;
      default: dg = m;
    endcase
    step(1); pon = '0; poff = '0; db = '0; dg = '0;
  endtask
  // 0 timer zero, 1 powered, 2 pull-down
  task automatic wait_bit(input int s, input int p, input logic v, input int lim);
    n = 0;
    while ((s == 0 ? tz[p] : s == 1 ? pwr[p] : gpd[p]) !== v && n < lim) begin
      step(1);
      n++;
    end
  endtask
  function automatic logic [11:0] fold(input int v);
    return v >= 180 ? 12'd2125 : 12'(300 + 1825 * v / 180);
  endfunction
  initial begin
    void'($urandom(88922));
    repeat (4) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    d = (8'($urandom) & 8'hc3) | 8'h14;
    reg_write(`TIMER_CFG_ADDR, d);
    reg_read(`TIMER_CFG_ADDR);
    check("cfg", rdata, d);
    reg_write(`FAULT_FLAGS_ADDR, 8'hff);
    reg_read(`FAULT_FLAGS_ADDR);
    check("flags ro", rdata, 0);
    reg_read(8'h40);
    check("unmapped", rdata, 0);
    $display("test registers done");
    ovl[0] = 1'b1;
    pulse(0, 4'h1);
    check("start pwr", pwr[0], 1);
    wait_bit(1, 0, 1'b0, 40 * TK);
    check("start end", n > 28 * TK && n <= 31 * TK, 1);
    reg_read(`FAULT_CLEAR_ADDR);
    check("start flag", rdata, 8'h1 << `FLAGS_START_LSB);
    reg_read(`FAULT_FLAGS_ADDR);
    check("cleared", rdata, 0);
    ovl[0] = 1'b0;
    pulse(0, 4'h1);
    step(3);
    check("blocked", pwr[0], 0);
    wait_bit(0, 0, 1'b1, 40 * 16 * TK);
    check("down", n > 28 * 16 * TK && n < 31 * 16 * TK, 1);
    step(600);
    check("floor", tz[0], 1);
    pulse(0, 4'h1);
    check("repower", pwr[0], 1);
    pulse(1, 4'h1);
    check("off", pwr[0], 0);
    $display("test start-up fault done");
    den[1] = 1'b1;
    pv[1] = 8'(180 + $urandom_range(0, 75));
    pulse(0, 4'h2);
    step(31 * TK + $urandom_range(0, 9));
    check("disc on", dact[1], 1);
    check("lvl full", lvl[1], fold(pv[1]));
    reg_read(`FAULT_FLAGS_ADDR);
    check("no fault", rdata, 0);
    pv[1] = 8'h00;
    ovl[1] = 1'b1;
    step(8);
    check("lvl min", lvl[1], fold(0));
    wait_bit(1, 1, 1'b0, 40 * TK);
    check("ovl time", n > 27 * TK && n <= 31 * TK, 1);
    reg_read(`FAULT_CLEAR_ADDR);
    check("ovl flag", rdata, 8'h2 << `FLAGS_OVL_LSB);
    ovl[1] = 1'b0;
    $display("test overload done");
    pulse(0, 4'h4);
    step(32 * TK);
    shr[2] = 1'b1;
    wait_bit(2, 2, 1'b1, 10);
    check("pd fast", n <= 6 && gon[2] === 1'b0, 1);
    shr[2] = 1'b0;
    wait_bit(2, 2, 1'b0, 3000);
    check("pd hold", n >= 2495 && n <= 2505, 1);
    step(3);
    check("regate", gon[2], 1);
    $display("test short done");
    am[3] = 1'b1;
    pulse(3, 4'h8);
    check("no arm", pwr[3], 0);
    pulse(2, 4'h8);
    pulse(3, 4'h8);
    check("auto on", pwr[3], 1);
    $display("test auto done");
    end_sim();
  end
endmodule // port_overcurrent_fault_timers_tb_top
`default_nettype wire
